// ---- core/acm_pkg.sv ----
// Purpose : Shared constants and types for the motion detect register bank.
// Assumes : Eight-bit register port, sixteen-bit signed samples at 1024 counts per g.
// Notes   : Offsets are the register port addresses.
package acm_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ACM_OFS_MAKER    = 8'h00;
  localparam logic [7:0] ACM_OFS_TRACE    = 8'h01;
  localparam logic [7:0] ACM_OFS_PART     = 8'h02;
  localparam logic [7:0] ACM_OFS_REVISION = 8'h03;
  localparam logic [7:0] ACM_OFS_SERIAL   = 8'h04;
  localparam logic [7:0] ACM_OFS_SOFT_RST = 8'h18;
  localparam logic [7:0] ACM_OFS_X_TRIM   = 8'h1e;
  localparam logic [7:0] ACM_OFS_Y_TRIM   = 8'h1f;
  localparam logic [7:0] ACM_OFS_Z_TRIM   = 8'h20;
  localparam logic [7:0] ACM_OFS_MOT_THR  = 8'h24;
  localparam logic [7:0] ACM_OFS_STL_THR  = 8'h25;
  localparam logic [7:0] ACM_OFS_STL_TIME = 8'h26;
  localparam logic [7:0] ACM_OFS_MOT_CTL  = 8'h27;
  localparam logic [7:0] ACM_OFS_BANDWIDTH_AND_RATE  = 8'h2c;
  localparam logic [7:0] ACM_OFS_EVENTS   = 8'h30;

  // ==========================================================================
  // Field positions and reset values
  localparam int         ACM_BIT_MOT_COUPLING = 7;
  localparam int         ACM_BIT_STL_COUPLING = 3;
  localparam int         ACM_BIT_LOW_POWER    = 4;
  localparam int         ACM_BIT_EVT_MOTION   = 4;
  localparam int         ACM_BIT_EVT_STILL    = 3;
  localparam logic [7:0] ACM_SOFT_RESET_KEY   = 8'h52;
  localparam logic [7:0] ACM_RST_CONFIG       = 8'h00;
  localparam logic [4:0] ACM_RST_BANDWIDTH_AND_RATE      = 5'h0a;

  // ==========================================================================
  // Scaling: trim is about 4 counts per code, thresholds 16 counts per code
  localparam int ACM_TRIM_SHIFT = 2;
  localparam int ACM_THR_SHIFT  = 4;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } acm_axes_t;

  typedef enum logic [1:0] {
    ACM_STL_IDLE,
    ACM_STL_TIMING,
    ACM_STL_DECLARED
  } acm_still_state_t;

endpackage

// ---- core/acm_motion_regs.sv ----
// Purpose : Configuration registers, offset trims and motion/stillness detector.
// Assumes : The serial port front end delivers decoded one-cycle read and write
//           strobes with an eight-bit address; samples arrive as one-cycle strobes.
// Notes   : Read data appears one cycle after the read strobe.
//
// Function
// - Fixed read-only maker, trace, part codes
// - Read-only silicon revision number at 0x03
// - Read-only serial number at 0x04
// - Writing 0x52 to 0x18 restores defaults
// - Trims are signed, 3.9 mg per count
// - Trim added to each axis output sample
// - Motion threshold unsigned, 15.625 mg per count
// - Stillness threshold unsigned, 15.625 mg per count
// - Stillness time one second per count
// - Stillness uses filtered samples, needs one sample
// - Zero time: stillness on first low sample after the entry sample
// - Coupling bits D7/D3: clear dc, set ac
// - Ac motion compares against captured start reference
// - Ac stillness reference refreshed when threshold exceeded
// - Axis enable bits; no axes disables function
// - Motion is OR of participating axes
// - Stillness is AND of participating axes
// - Low power bit D4 of rate register
// - Four-bit rate field, resets to 0x0A
// - Reading 0x30 clears motion and stillness flags
// - In sleep only motion detection operates
`timescale 1ns/1ps

module acm_motion_regs #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary identification value.
  parameter logic [7:0] TRACE_CODE = 8'h3c,  // Arbitrary identification value.
  parameter logic [7:0] PART_CODE  = 8'h77,  // Arbitrary identification value.
  parameter logic [7:0] REVISION   = 8'h00,
  parameter logic [7:0] SERIAL_NUM = 8'h00
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // Register port
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [7:0]        reg_rdata_out,
  // Sample inputs
  input  wire logic              raw_valid_in,
  input  wire acm_pkg::acm_axes_t raw_in,
  input  wire logic              filt_valid_in,
  input  wire acm_pkg::acm_axes_t filt_in,
  input  wire logic              sleep_in,
  // Output data and events
  output acm_pkg::acm_axes_t     data_out,
  output logic                   data_valid_out,
  output logic                   motion_out,
  output logic                   stillness_out,
  // Configuration seen by the sensing core
  output logic                   low_power_out,
  output logic      [3:0]        rate_out,
  output logic                   soft_reset_out
);
  import acm_pkg::*;

  // ==========================================================================
  // Helper functions
  // Magnitude of a difference, one bit wider so full-scale swings cannot wrap.
  function automatic logic [16:0] mag(input logic signed [15:0] a,
                                     input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    mag = d[16] ? 17'(-d) : 17'(d);
  endfunction

  function automatic logic [16:0] thr_counts(input logic [7:0] t);
    thr_counts = 17'({t, 4'h0});
  endfunction

  // Output samples per second for a rate code; slow codes round to one sample.
  function automatic logic [11:0] rate_sps(input logic [3:0] code);
    case (code)
      4'hf:    rate_sps = 12'd3200;
      4'he:    rate_sps = 12'd1600;
      4'hd:    rate_sps = 12'd800;
      4'hc:    rate_sps = 12'd400;
      4'hb:    rate_sps = 12'd200;
      4'ha:    rate_sps = 12'd100;
      4'h9:    rate_sps = 12'd50;
      4'h8:    rate_sps = 12'd25;
      4'h7:    rate_sps = 12'd12;
      4'h6:    rate_sps = 12'd6;
      4'h5:    rate_sps = 12'd3;
      default: rate_sps = 12'd1;
    endcase
  endfunction

  // ==========================================================================
  // Configuration registers
  logic [7:0]       x_trim_reg;
  logic [7:0]       y_trim_reg;
  logic [7:0]       z_trim_reg;
  logic [7:0]       mot_thr_reg;
  logic [7:0]       stl_thr_reg;
  logic [7:0]       stl_time_reg;
  logic [7:0]       mot_ctl_reg;
  logic [4:0]       bandwidth_and_rate_reg;
  logic             mot_flag_reg;
  logic             stl_flag_reg;
  logic [7:0]       rdata_reg;
  logic             soft_rst_reg;

  wire wr_soft_rst  = reg_wr_in && (reg_addr_in == ACM_OFS_SOFT_RST);
  wire soft_rst_cmd = wr_soft_rst && (reg_wdata_in == ACM_SOFT_RESET_KEY);
  wire wr_x_trim    = reg_wr_in && (reg_addr_in == ACM_OFS_X_TRIM);
  wire wr_y_trim    = reg_wr_in && (reg_addr_in == ACM_OFS_Y_TRIM);
  wire wr_z_trim    = reg_wr_in && (reg_addr_in == ACM_OFS_Z_TRIM);
  wire wr_mot_thr   = reg_wr_in && (reg_addr_in == ACM_OFS_MOT_THR);
  wire wr_stl_thr   = reg_wr_in && (reg_addr_in == ACM_OFS_STL_THR);
  wire wr_stl_time  = reg_wr_in && (reg_addr_in == ACM_OFS_STL_TIME);
  wire wr_mot_ctl   = reg_wr_in && (reg_addr_in == ACM_OFS_MOT_CTL);
  wire wr_bandwidth_and_rate   = reg_wr_in && (reg_addr_in == ACM_OFS_BANDWIDTH_AND_RATE);
  wire rd_events    = reg_rd_in && (reg_addr_in == ACM_OFS_EVENTS);

  // Soft reset returns every written register to its default in one cycle.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      x_trim_reg   <= ACM_RST_CONFIG;
      y_trim_reg   <= ACM_RST_CONFIG;
      z_trim_reg   <= ACM_RST_CONFIG;
      mot_thr_reg  <= ACM_RST_CONFIG;
      stl_thr_reg  <= ACM_RST_CONFIG;
      stl_time_reg <= ACM_RST_CONFIG;
      mot_ctl_reg  <= ACM_RST_CONFIG;
      bandwidth_and_rate_reg  <= ACM_RST_BANDWIDTH_AND_RATE;
    end else if (soft_rst_cmd) begin
      x_trim_reg   <= ACM_RST_CONFIG;
      y_trim_reg   <= ACM_RST_CONFIG;
      z_trim_reg   <= ACM_RST_CONFIG;
      mot_thr_reg  <= ACM_RST_CONFIG;
      stl_thr_reg  <= ACM_RST_CONFIG;
      stl_time_reg <= ACM_RST_CONFIG;
      mot_ctl_reg  <= ACM_RST_CONFIG;
      bandwidth_and_rate_reg  <= ACM_RST_BANDWIDTH_AND_RATE;
    end else begin
      if (wr_x_trim)   x_trim_reg   <= reg_wdata_in;
      if (wr_y_trim)   y_trim_reg   <= reg_wdata_in;
      if (wr_z_trim)   z_trim_reg   <= reg_wdata_in;
      if (wr_mot_thr)  mot_thr_reg  <= reg_wdata_in;
      if (wr_stl_thr)  stl_thr_reg  <= reg_wdata_in;
      if (wr_stl_time) stl_time_reg <= reg_wdata_in;
      if (wr_mot_ctl)  mot_ctl_reg  <= reg_wdata_in;
      if (wr_bandwidth_and_rate)  bandwidth_and_rate_reg  <= reg_wdata_in[4:0];
    end
  end

  // ==========================================================================
  // Read path; unmapped and reserved addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    if (reg_addr_in == ACM_OFS_MAKER) begin
      rd_mux = MAKER_CODE;
    end else if (reg_addr_in == ACM_OFS_TRACE) begin
      rd_mux = TRACE_CODE;
    end else if (reg_addr_in == ACM_OFS_PART) begin
      rd_mux = PART_CODE;
    end else if (reg_addr_in == ACM_OFS_REVISION) begin
      rd_mux = REVISION;
    end else if (reg_addr_in == ACM_OFS_SERIAL) begin
      rd_mux = SERIAL_NUM;
    end else if (reg_addr_in == ACM_OFS_X_TRIM) begin
      rd_mux = x_trim_reg;
    end else if (reg_addr_in == ACM_OFS_Y_TRIM) begin
      rd_mux = y_trim_reg;
    end else if (reg_addr_in == ACM_OFS_Z_TRIM) begin
      rd_mux = z_trim_reg;
    end else if (reg_addr_in == ACM_OFS_MOT_THR) begin
      rd_mux = mot_thr_reg;
    end else if (reg_addr_in == ACM_OFS_STL_THR) begin
      rd_mux = stl_thr_reg;
    end else if (reg_addr_in == ACM_OFS_STL_TIME) begin
      rd_mux = stl_time_reg;
    end else if (reg_addr_in == ACM_OFS_MOT_CTL) begin
      rd_mux = mot_ctl_reg;
    end else if (reg_addr_in == ACM_OFS_BANDWIDTH_AND_RATE) begin
      rd_mux = {3'h0, bandwidth_and_rate_reg};
    end else if (reg_addr_in == ACM_OFS_EVENTS) begin
      rd_mux = 8'h00;
      rd_mux[ACM_BIT_EVT_MOTION] = mot_flag_reg;
      rd_mux[ACM_BIT_EVT_STILL]  = stl_flag_reg;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Read data is registered and held, so a slow host always sees a stable byte.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg    <= 8'h00;
      soft_rst_reg <= 1'b0;
    end else begin
      rdata_reg    <= reg_rd_in ? rd_mux : rdata_reg;
      soft_rst_reg <= soft_rst_cmd;
    end
  end

  // ==========================================================================
  // Offset trim and output data
  logic signed [15:0] raw_a  [3];
  logic signed [15:0] filt_a [3];
  logic signed [15:0] trim_a [3];
  logic        [2:0]  mot_en;
  logic        [2:0]  stl_en;
  assign raw_a[0]  = raw_in.x;
  assign raw_a[1]  = raw_in.y;
  assign raw_a[2]  = raw_in.z;
  assign filt_a[0] = filt_in.x;
  assign filt_a[1] = filt_in.y;
  assign filt_a[2] = filt_in.z;
  assign trim_a[0] = 16'(signed'(x_trim_reg)) <<< ACM_TRIM_SHIFT;
  assign trim_a[1] = 16'(signed'(y_trim_reg)) <<< ACM_TRIM_SHIFT;
  assign trim_a[2] = 16'(signed'(z_trim_reg)) <<< ACM_TRIM_SHIFT;
  assign mot_en    = {mot_ctl_reg[4], mot_ctl_reg[5], mot_ctl_reg[6]};
  // Index 0 is the x axis; the stillness enables sit in reverse order at bits 2:0.
  assign stl_en    = {mot_ctl_reg[0], mot_ctl_reg[1], mot_ctl_reg[2]};

  // Trimmed output sample; the sum wraps, the host keeps trims in range.
  logic signed [15:0] out_a [3];
  acm_axes_t          data_reg;
  logic               data_valid_reg;
  assign out_a[0] = 16'(filt_a[0] + trim_a[0]);
  assign out_a[1] = 16'(filt_a[1] + trim_a[1]);
  assign out_a[2] = 16'(filt_a[2] + trim_a[2]);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      data_reg       <= '0;
      data_valid_reg <= 1'b0;
    end else begin
      data_valid_reg <= filt_valid_in;
      if (filt_valid_in) data_reg <= '{out_a[0], out_a[1], out_a[2]};
    end
  end

  // ==========================================================================
  // Motion detector on unfiltered samples
  logic signed [15:0] mot_ref_reg [3];
  logic               mot_armed_reg;
  logic        [2:0]  mot_above;
  wire mot_ac      = mot_ctl_reg[ACM_BIT_MOT_COUPLING];
  wire mot_active  = |mot_en;
  // Any control change drops the reference; the next raw sample re-arms.
  wire mot_restart = wr_mot_ctl || soft_rst_cmd || !mot_active;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      mot_above[i] = mot_en[i] && (mag(raw_a[i], mot_ac ? mot_ref_reg[i] : 16'sh0000)
                                   > thr_counts(mot_thr_reg));
    end
  end
  wire mot_hit = mot_armed_reg && raw_valid_in && (|mot_above);

  // Ac mode takes a fresh reference after each trigger so motion is relative to rest.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mot_armed_reg <= 1'b0;
      for (int i = 0; i < 3; i++) mot_ref_reg[i] <= 16'sh0000;
    end else if (mot_restart) begin
      mot_armed_reg <= 1'b0;
    end else if (raw_valid_in && (!mot_armed_reg || (mot_hit && mot_ac))) begin
      mot_armed_reg <= 1'b1;
      for (int i = 0; i < 3; i++) mot_ref_reg[i] <= raw_a[i];
    end
  end

  // ==========================================================================
  // Stillness detector on filtered samples
  acm_still_state_t   stl_state_reg;
  acm_still_state_t   stl_state_next;
  logic signed [15:0] stl_ref_reg [3];
  logic        [11:0] stl_smp_reg;
  logic        [7:0]  stl_sec_reg;
  logic        [2:0]  stl_high;
  wire stl_ac     = mot_ctl_reg[ACM_BIT_STL_COUPLING];
  // A control, stillness threshold or stillness time write parks the detector in idle
  // until the next filtered sample, so a new threshold or time never meets a half-counted interval.
  wire wr_stl_ctl_any = wr_mot_ctl || wr_stl_thr || wr_stl_time || soft_rst_cmd;
  wire stl_run    = (|stl_en) && !sleep_in && !wr_stl_ctl_any;
  wire [11:0] sps = rate_sps(bandwidth_and_rate_reg[3:0]);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      stl_high[i] = stl_en[i] && (mag(filt_a[i], stl_ac ? stl_ref_reg[i] : 16'sh0000)
                                  >= thr_counts(stl_thr_reg));
    end
  end
  wire all_low  = !(|stl_high);
  // Seconds are counted in output samples, so the timer follows the rate code.
  wire sec_done = (stl_smp_reg == sps - 12'd1);
  wire time_met = (stl_time_reg == 8'h00) ||
                  (sec_done && (stl_sec_reg == stl_time_reg - 8'h01));

  always_comb begin
    stl_state_next = stl_state_reg;
    case (stl_state_reg)
      ACM_STL_IDLE: begin
        if (stl_run && filt_valid_in) stl_state_next = ACM_STL_TIMING;
      end
      ACM_STL_TIMING: begin
        if (filt_valid_in && all_low && time_met) stl_state_next = ACM_STL_DECLARED;
      end
      ACM_STL_DECLARED: begin
        if (filt_valid_in && !all_low) stl_state_next = ACM_STL_TIMING;
      end
      default: stl_state_next = ACM_STL_IDLE;
    endcase
    if (!stl_run) stl_state_next = ACM_STL_IDLE;
  end
  wire stl_hit = (stl_state_reg == ACM_STL_TIMING) && stl_run && filt_valid_in &&
                 all_low && time_met;

  // The reference is loaded on entry and refreshed on each high sample.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stl_state_reg <= ACM_STL_IDLE;
      stl_smp_reg   <= 12'h000;
      stl_sec_reg   <= 8'h00;
      for (int i = 0; i < 3; i++) stl_ref_reg[i] <= 16'sh0000;
    end else begin
      stl_state_reg <= stl_state_next;
      if (stl_state_reg != ACM_STL_TIMING || (filt_valid_in && !all_low)) begin
        stl_smp_reg <= 12'h000;
        stl_sec_reg <= 8'h00;
      end else if (filt_valid_in) begin
        stl_smp_reg <= sec_done ? 12'h000 : stl_smp_reg + 12'h001;
        stl_sec_reg <= sec_done ? stl_sec_reg + 8'h01 : stl_sec_reg;
      end
      if (filt_valid_in && ((stl_state_reg == ACM_STL_IDLE) || !all_low)) begin
        for (int i = 0; i < 3; i++) stl_ref_reg[i] <= filt_a[i];
      end
    end
  end

  // ==========================================================================
  // Event flags; a new event in the read cycle survives the clear
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mot_flag_reg <= 1'b0;
      stl_flag_reg <= 1'b0;
    end else if (soft_rst_cmd) begin
      mot_flag_reg <= 1'b0;
      stl_flag_reg <= 1'b0;
    end else begin
      mot_flag_reg <= mot_hit || (mot_flag_reg && !rd_events);
      stl_flag_reg <= stl_hit || (stl_flag_reg && !rd_events);
    end
  end

  // ==========================================================================
  // Outputs
  // The soft reset pulse tells the sensing core to restart its start-up sequence.
  assign reg_rdata_out  = rdata_reg;
  assign data_out       = data_reg;
  assign data_valid_out = data_valid_reg;
  assign motion_out     = mot_flag_reg;
  assign stillness_out  = stl_flag_reg;
  assign low_power_out  = bandwidth_and_rate_reg[ACM_BIT_LOW_POWER];
  assign rate_out       = bandwidth_and_rate_reg[3:0];
  assign soft_reset_out = soft_rst_reg;

endmodule

// ---- tb/acm_motion_regs_props.sv ----
// Purpose : Port-level checks of the motion detect register bank.
// Assumes : One clock domain with an asynchronous active-high reset.
// Notes   : Attached to every instance through the bind after the module.
`timescale 1ns/1ps

module acm_motion_regs_props
  import acm_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] TRACE_CODE = 8'h3c,
  parameter logic [7:0] PART_CODE  = 8'h77
) (
  // Clock and reset
  input wire logic               clk_sys_in,
  input wire logic               rst_in,
  // Register port
  input wire logic [7:0]         reg_addr_in,
  input wire logic [7:0]         reg_wdata_in,
  input wire logic               reg_wr_in,
  input wire logic               reg_rd_in,
  input wire logic [7:0]         reg_rdata_out,
  // Samples
  input wire logic               raw_valid_in,
  input wire acm_pkg::acm_axes_t raw_in,
  input wire logic               filt_valid_in,
  input wire acm_pkg::acm_axes_t filt_in,
  input wire logic               sleep_in,
  // Outputs
  input wire acm_pkg::acm_axes_t data_out,
  input wire logic               data_valid_out,
  input wire logic               motion_out,
  input wire logic               stillness_out,
  input wire logic               low_power_out,
  input wire logic [3:0]         rate_out,
  input wire logic               soft_reset_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  wire soft_wr = reg_wr_in && reg_addr_in == ACM_OFS_SOFT_RST &&
                 reg_wdata_in == ACM_SOFT_RESET_KEY;
  wire evt_rd  = reg_rd_in && reg_addr_in == ACM_OFS_EVENTS;

  // ==========================================================================
  // Assertions
  a_ident_read: assert property (reg_rd_in && reg_addr_in <= ACM_OFS_PART |=>
    reg_rdata_out == ($past(reg_addr_in) == ACM_OFS_MAKER ? MAKER_CODE :
    ($past(reg_addr_in) == ACM_OFS_TRACE ? TRACE_CODE : PART_CODE)))
    else $error("identification read wrong");
  a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_soft_pulse: assert property (soft_wr |=> soft_reset_out)
    else $error("soft reset pulse missing");
  a_soft_cause: assert property (soft_reset_out |-> $past(soft_wr) && rate_out == 4'ha
    && !low_power_out) else $error("soft reset without key or defaults");
  a_rate_write: assert property (reg_wr_in && reg_addr_in == ACM_OFS_BANDWIDTH_AND_RATE |=>
    {low_power_out, rate_out} == $past(reg_wdata_in[4:0])) else $error("rate write lost");
  a_data_valid: assert property (data_valid_out == $past(filt_valid_in))
    else $error("output sample strobe wrong");
  a_motion_cause: assert property ($rose(motion_out) |-> $past(raw_valid_in))
    else $error("motion rose without a raw sample");
  a_still_cause: assert property ($rose(stillness_out) |->
    $past(filt_valid_in) && !$past(sleep_in)) else $error("stillness rose without cause");
  a_flag_hold: assert property (motion_out && !reg_wr_in && !evt_rd |=> motion_out)
    else $error("motion flag dropped");
  a_evt_clear: assert property (evt_rd && !raw_valid_in && !filt_valid_in |=>
    !motion_out && !stillness_out) else $error("event read did not clear flags");

  c_soft: cover property (soft_wr ##1 soft_reset_out);
  c_motion: cover property ($rose(motion_out));
  c_still: cover property ($rose(stillness_out));
endmodule

bind acm_motion_regs acm_motion_regs_props #(
  .MAKER_CODE(MAKER_CODE), .TRACE_CODE(TRACE_CODE), .PART_CODE(PART_CODE)
) u_props (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .raw_valid_in(raw_valid_in), .raw_in(raw_in),
  .filt_valid_in(filt_valid_in), .filt_in(filt_in), .sleep_in(sleep_in),
  .data_out(data_out), .data_valid_out(data_valid_out), .motion_out(motion_out),
  .stillness_out(stillness_out), .low_power_out(low_power_out), .rate_out(rate_out),
  .soft_reset_out(soft_reset_out)
);

// ---- tb/acm_host_model.sv ----
// Purpose : Host side of the register port, one byte per access.
// Assumes : Strobes are one-cycle pulses; read data one cycle after the read edge.
// Notes   : Address and data are inverted when idle so stale values never match.
`timescale 1ns/1ps

module acm_host_model (
  // Clock
  input  wire logic       clk_sys_in,
  // Register port
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out
);
  initial begin
    reg_addr_out = 8'hff;
    reg_wdata_out = 8'hff;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  // ==========================================================================
  // Accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    #1;
    d = reg_rdata_in;
  endtask
endmodule

// ---- tb/acm_motion_regs_test.sv ----
// Purpose : Self-checking bench of the motion detect register bank.
// Assumes : Host model drives the register port; bench drives samples.
// Notes   : Slow rate code keeps stillness time counts to a few samples.
`timescale 1ns/1ps

module acm_motion_regs_test;
  import acm_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} acm_row_t;
  localparam logic [7:0] MK = 8'h5a;  // Arbitrary identification value.
  localparam logic [7:0] TR = 8'h3c;  // Arbitrary identification value.
  localparam logic [7:0] PT = 8'h77;  // Arbitrary identification value.
  localparam acm_row_t ROWS [16] = '{
    '{8'h00, 8'hff, MK}, '{8'h01, 8'hff, TR}, '{8'h02, 8'hff, PT}, '{8'h03, 8'hff, 8'h00},
    '{8'h04, 8'hff, 8'h00}, '{8'h18, 8'h11, 8'h00}, '{8'h1e, 8'h81, 8'h81},
    '{8'h1f, 8'h7f, 8'h7f}, '{8'h20, 8'h01, 8'h01}, '{8'h24, 8'ha5, 8'ha5},
    '{8'h25, 8'h5a, 8'h5a}, '{8'h26, 8'h33, 8'h33}, '{8'h27, 8'hff, 8'hff},
    '{8'h2c, 8'hff, 8'h1f}, '{8'h10, 8'hff, 8'h00}, '{8'h21, 8'hff, 8'h00}};

  logic clk_sys_in = 1'b0;
  logic rst_in, raw_valid_in, filt_valid_in, sleep_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, data_valid_out, motion_out, stillness_out, low_power_out, soft_reset_out;
  logic [3:0] rate_out;
  acm_axes_t raw_in, filt_in, data_out;
  int miscompares, num_checks, cycles;

  always #20 clk_sys_in = ~clk_sys_in;

  acm_host_model u_host (.clk_sys_in(clk_sys_in), .reg_rdata_in(reg_rdata),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd));

  acm_motion_regs #(.MAKER_CODE(MK), .TRACE_CODE(TR), .PART_CODE(PT)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .raw_valid_in(raw_valid_in), .raw_in(raw_in),
    .filt_valid_in(filt_valid_in), .filt_in(filt_in), .sleep_in(sleep_in),
    .data_out(data_out), .data_valid_out(data_valid_out), .motion_out(motion_out),
    .stillness_out(stillness_out), .low_power_out(low_power_out), .rate_out(rate_out),
    .soft_reset_out(soft_reset_out));

  // ==========================================================================
  // Helpers
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic smp(input logic f, input logic [15:0] x, input logic [15:0] y,
                     input logic [15:0] z);
    @(posedge clk_sys_in);
    filt_valid_in <= f;
    raw_valid_in <= !f;
    filt_in <= f ? {x, y, z} : ~filt_in;
    raw_in <= f ? ~raw_in : {x, y, z};
    @(posedge clk_sys_in);
    filt_valid_in <= 1'b0;
    raw_valid_in <= 1'b0;
    #1;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  // ==========================================================================
  // Sequence
  initial begin
    {rst_in, raw_valid_in, filt_valid_in, sleep_in} = 4'h8;
    raw_in = '0;
    filt_in = '0;
    {miscompares, num_checks, cycles} = '0;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk({low_power_out, rate_out}, 5'h0a);
    u_host.rd(ACM_OFS_BANDWIDTH_AND_RATE, rv);
    chk(rv, 8'h0a);
    foreach (ROWS[i]) begin
      u_host.wr(ROWS[i].a, ROWS[i].w);
      u_host.rd(ROWS[i].a, rv);
      chk(rv, ROWS[i].e);
    end
    chk({low_power_out, rate_out}, 5'h1f);
    u_host.wr(ACM_OFS_SOFT_RST, ACM_SOFT_RESET_KEY);
    #1 chk(soft_reset_out, 1'b1);
    for (int i = 6; i < 14; i++) begin
      u_host.rd(ROWS[i].a, rv);
      chk(rv, ROWS[i].a == ACM_OFS_BANDWIDTH_AND_RATE ? 8'h0a : 8'h00);
    end
    u_host.wr(ACM_OFS_X_TRIM, 8'h7f);
    u_host.wr(ACM_OFS_Y_TRIM, 8'h80);
    u_host.wr(ACM_OFS_Z_TRIM, 8'h01);
    smp(1'b1, 16'h0064, 16'h0000, 16'hffff);
    chk({data_valid_out, data_out}, 49'h1_0260_fe00_0003);
    u_host.wr(ACM_OFS_MOT_THR, 8'h02);
    u_host.wr(ACM_OFS_MOT_CTL, 8'h40);
    smp(1'b0, 16'h0000, 16'h03e8, 16'h0000);
    smp(1'b0, 16'h0020, 16'h03e8, 16'h0000);
    chk(motion_out, 1'b0);
    smp(1'b0, 16'h0021, 16'h0000, 16'h0000);
    chk(motion_out, 1'b1);
    u_host.rd(ACM_OFS_EVENTS, rv);
    chk({rv, motion_out}, 9'h020);
    u_host.wr(ACM_OFS_MOT_CTL, 8'hc0);
    smp(1'b0, 16'h01f4, 16'h0000, 16'h0000);
    smp(1'b0, 16'h0214, 16'h0000, 16'h0000);
    chk(motion_out, 1'b0);
    smp(1'b0, 16'h0215, 16'h0000, 16'h0000);
    chk(motion_out, 1'b1);
    u_host.rd(ACM_OFS_EVENTS, rv);
    u_host.wr(ACM_OFS_STL_THR, 8'h02);
    u_host.wr(ACM_OFS_STL_TIME, 8'h00);
    u_host.wr(ACM_OFS_MOT_CTL, 8'h03);
    smp(1'b1, 16'h0400, 16'h000a, 16'h000a);
    smp(1'b1, 16'h0400, 16'h000a, 16'h0028);
    chk(stillness_out, 1'b0);
    smp(1'b1, 16'h0400, 16'h000a, 16'h000a);
    chk(stillness_out, 1'b1);
    u_host.rd(ACM_OFS_EVENTS, rv);
    chk(rv, 8'h08);
    @(posedge clk_sys_in);
    sleep_in <= 1'b1;
    u_host.wr(ACM_OFS_MOT_CTL, 8'h03);
    repeat (3) smp(1'b1, 16'h0000, 16'h0001, 16'h0001);
    chk(stillness_out, 1'b0);
    @(posedge clk_sys_in) sleep_in <= 1'b0;
    u_host.wr(ACM_OFS_BANDWIDTH_AND_RATE, 8'h00);
    u_host.wr(ACM_OFS_STL_TIME, 8'h02);
    u_host.wr(ACM_OFS_MOT_CTL, 8'h0b);
    smp(1'b1, 16'h0000, 16'h0001, 16'h0001);
    smp(1'b1, 16'h0000, 16'h0001, 16'h0001);
    smp(1'b1, 16'h0000, 16'h0001, 16'h0100);
    smp(1'b1, 16'h0000, 16'h0001, 16'h0001);
    chk(stillness_out, 1'b0);
    smp(1'b1, 16'h0000, 16'h0001, 16'h0001);
    chk(stillness_out, 1'b0);
    smp(1'b1, 16'h0000, 16'h0001, 16'h0001);
    chk(stillness_out, 1'b1);
    @(posedge clk_sys_in) rst_in <= 1'b1;
    @(posedge clk_sys_in) rst_in <= 1'b0;
    u_host.rd(ACM_OFS_STL_TIME, rv);
    chk({rv, stillness_out, low_power_out, rate_out}, 14'h000a);
    test_done();
  end
endmodule
